//--- core/bsf_pkg.sv
// Package: register map, reset values and field layout for bank select and fault flags
package bsf_pkg;
  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] BANK_CHOICE_OFS = 8'hF0;
  localparam logic [7:0] FAULT_FLAG_ONE_OFS = 8'hF1;
  localparam logic [7:0] FAULT_FLAG_TWO_OFS = 8'hF2;
  // ----------------------------------------
  // Reset values and fields
  // ----------------------------------------
  localparam logic [7:0] BANK_CHOICE_RST = 8'h00;
  localparam logic [7:0] FAULT_FLAG_RST = 8'h00;
  localparam int BANK_BIT = 0;
  localparam int FLAG_W = 8;
  // ----------------------------------------
  // Power states
  // ----------------------------------------
  typedef enum logic [0:0] {
    BSF_SHUTDOWN = 1'b0,
    BSF_ACTIVE = 1'b1
  } bsf_state_e;
endpackage

//--- core/bsf_bank_fault.sv
// Bank choice register, sticky fault flags with write-one-to-clear and fault interrupt
// Functional notes
// - Bit 0 of bank choice picks bank
// - Bank choice at F0h, resets to 00h
// - Activity input selects active or shutdown state
// - Fault interrupt goes low on detected fault
// - Flag clears only by host writing one
// - Flags stay set after fault disappears
module bsf_bank_fault (
  input wire logic i_mclk,
  input wire logic i_nrst,
  input wire logic i_activity_request_input,
  input wire logic [7:0] i_fault_one,
  input wire logic [7:0] i_fault_two,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  output logic [7:0] o_reg_rdata,
  output logic o_reg_rvalid,
  output logic o_bank_sel,
  output logic o_active,
  output logic o_fault_interrupt_output_n
);
  logic [7:0] bank_choice_r;
  logic [7:0] flag_one_r;
  logic [7:0] flag_two_r;
  logic [7:0] flag_one_nxt;
  logic [7:0] flag_two_nxt;
  bsf_pkg::bsf_state_e state_r;

  function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
    hit = (addr == ofs);
  endfunction

  // ----------------------------------------
  // Bank choice register
  // ----------------------------------------
  // Reserved upper bits are stored and read back as written
  always_ff @(posedge i_mclk) begin
    if (!i_nrst) begin
      bank_choice_r <= bsf_pkg::BANK_CHOICE_RST;
    end else if (i_reg_wr && hit(i_reg_addr, bsf_pkg::BANK_CHOICE_OFS)) begin
      bank_choice_r <= i_reg_wdata;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_nrst) begin
      o_bank_sel <= 1'b0;
    end else begin
      o_bank_sel <= bank_choice_r[bsf_pkg::BANK_BIT];
    end
  end

  // ----------------------------------------
  // Sticky fault flags
  // ----------------------------------------
  // A new fault in the clearing cycle keeps its flag set
  // A clearing write only reaches the flag register it addresses
  always_comb begin
    flag_one_nxt = flag_one_r;
    flag_two_nxt = flag_two_r;
    if (i_reg_wr && hit(i_reg_addr, bsf_pkg::FAULT_FLAG_ONE_OFS)) begin
      flag_one_nxt = flag_one_r & ~i_reg_wdata;
    end
    if (i_reg_wr && hit(i_reg_addr, bsf_pkg::FAULT_FLAG_TWO_OFS)) begin
      flag_two_nxt = flag_two_r & ~i_reg_wdata;
    end
    flag_one_nxt = flag_one_nxt | i_fault_one;
    flag_two_nxt = flag_two_nxt | i_fault_two;
  end

  always_ff @(posedge i_mclk) begin
    if (!i_nrst) begin
      flag_one_r <= bsf_pkg::FAULT_FLAG_RST;
      flag_two_r <= bsf_pkg::FAULT_FLAG_RST;
    end else begin
      flag_one_r <= flag_one_nxt;
      flag_two_r <= flag_two_nxt;
    end
  end

  // ----------------------------------------
  // Interrupt and power state
  // ----------------------------------------
  // Interrupt trails the flags by one cycle so the pin comes straight from a flop
  always_ff @(posedge i_mclk) begin
    if (!i_nrst) begin
      o_fault_interrupt_output_n <= 1'b1;
    end else begin
      o_fault_interrupt_output_n <= ~(|flag_one_r | |flag_two_r);
    end
  end

  // Activity level is used as is: it is synchronous, so no filter is needed
  always_ff @(posedge i_mclk) begin
    if (!i_nrst) begin
      state_r <= bsf_pkg::BSF_SHUTDOWN;
    end else begin
      case (i_activity_request_input)
        1'b1: state_r <= bsf_pkg::BSF_ACTIVE;
        default: state_r <= bsf_pkg::BSF_SHUTDOWN;
      endcase
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_nrst) begin
      o_active <= 1'b0;
    end else begin
      o_active <= (state_r == bsf_pkg::BSF_ACTIVE);
    end
  end

  // ----------------------------------------
  // Register read port
  // ----------------------------------------
  // Unmapped offsets read as zero
  // Read data stands one cycle only; a late sampler sees zero
  always_ff @(posedge i_mclk) begin
    if (!i_nrst) begin
      o_reg_rdata <= 8'h00;
      o_reg_rvalid <= 1'b0;
    end else begin
      o_reg_rvalid <= i_reg_rd;
      if (!i_reg_rd) begin
        o_reg_rdata <= 8'h00;
      end else if (hit(i_reg_addr, bsf_pkg::BANK_CHOICE_OFS)) begin
        o_reg_rdata <= bank_choice_r;
      end else if (hit(i_reg_addr, bsf_pkg::FAULT_FLAG_ONE_OFS)) begin
        o_reg_rdata <= flag_one_r;
      end else if (hit(i_reg_addr, bsf_pkg::FAULT_FLAG_TWO_OFS)) begin
        o_reg_rdata <= flag_two_r;
      end else begin
        o_reg_rdata <= 8'h00;
      end
    end
  end

  // ----------------------------------------
  // Assertions: bank choice and read port
  // ----------------------------------------
  chk_bank_reset: assert property (@(posedge i_mclk) !i_nrst |=> bank_choice_r == 8'h00)
    else $error("bank choice not zero after reset");
  chk_bank_write: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    i_reg_wr && i_reg_addr == 8'hF0 |=> ##1 o_bank_sel == $past(i_reg_wdata[0], 2))
    else $error("bank select did not follow write");
  chk_bank_store: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    i_reg_wr && i_reg_addr == 8'hF0 |=> bank_choice_r == $past(i_reg_wdata))
    else $error("bank choice did not store all bits");
  chk_bank_steady: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    !(i_reg_wr && i_reg_addr == 8'hF0) |=> $stable(bank_choice_r))
    else $error("bank choice changed without write");
  chk_bank_readback: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    i_reg_rd && i_reg_addr == 8'hF0 |=> o_reg_rvalid && o_reg_rdata == $past(bank_choice_r))
    else $error("bank choice read back wrong");
  chk_read_idle: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    !i_reg_rd |=> !o_reg_rvalid && o_reg_rdata == 8'h00)
    else $error("read port not idle");
  chk_read_unmapped: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    i_reg_rd && !(i_reg_addr inside {8'hF0, 8'hF1, 8'hF2}) |=> o_reg_rdata == 8'h00)
    else $error("unmapped offset read not zero");

  // ----------------------------------------
  // Assertions: power state
  // ----------------------------------------
  chk_active_follow: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    i_activity_request_input ##1 i_nrst |=> o_active)
    else $error("active state not entered");
  chk_shutdown_state_follow: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    !i_activity_request_input ##1 i_nrst |=> !o_active)
    else $error("shutdown state not entered");

  // ----------------------------------------
  // Assertions: fault flags and interrupt
  // ----------------------------------------
  chk_irq_assert: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    (|i_fault_one) |=> ##1 !o_fault_interrupt_output_n)
    else $error("interrupt not asserted on fault");
  chk_flag_sticky: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    flag_one_r[0] && !(i_reg_wr && i_reg_addr == 8'hF1 && i_reg_wdata[0]) |=> flag_one_r[0])
    else $error("flag cleared without host write");
  chk_flag_clear: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    i_reg_wr && i_reg_addr == 8'hF2 && i_reg_wdata[3] && !i_fault_two[3] |=> !flag_two_r[3])
    else $error("write one did not clear flag");
  chk_irq_release: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    flag_one_r == 8'h00 && flag_two_r == 8'h00 |=> o_fault_interrupt_output_n)
    else $error("interrupt held with no flags");
  chk_irq_two: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    (|i_fault_two) |=> ##1 !o_fault_interrupt_output_n)
    else $error("interrupt not asserted on second register fault");
  chk_irq_hold: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    flag_one_r != 8'h00 || flag_two_r != 8'h00 |=> !o_fault_interrupt_output_n)
    else $error("interrupt released with a flag set");
  chk_flag_set_one: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    (|i_fault_one) |=> (flag_one_r & $past(i_fault_one)) == $past(i_fault_one))
    else $error("fault did not set first register flag");
  chk_flag_set_two: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    (|i_fault_two) |=> (flag_two_r & $past(i_fault_two)) == $past(i_fault_two))
    else $error("fault did not set second register flag");
  chk_flag_keep_one: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    !(i_reg_wr && i_reg_addr == 8'hF1) |=> (flag_one_r & $past(flag_one_r)) == $past(flag_one_r))
    else $error("first register flag dropped without clearing write");
  chk_flag_keep_two: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    !(i_reg_wr && i_reg_addr == 8'hF2) |=> (flag_two_r & $past(flag_two_r)) == $past(flag_two_r))
    else $error("second register flag dropped without clearing write");
  chk_clear_one: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    i_reg_wr && i_reg_addr == 8'hF1 |=> (flag_one_r & $past(i_reg_wdata) & ~$past(i_fault_one)) == 8'h00)
    else $error("write one did not clear first register flag");
  chk_flag_readback: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    i_reg_rd && i_reg_addr == 8'hF1 |=> o_reg_rdata == $past(flag_one_r))
    else $error("flag register read back wrong");

  // ----------------------------------------
  // Cover points
  // ----------------------------------------
  cov_bank_one: cover property (@(posedge i_mclk) disable iff (!i_nrst) o_bank_sel ##1 !o_bank_sel);
  cov_fault_clear: cover property (@(posedge i_mclk) disable iff (!i_nrst)
    !o_fault_interrupt_output_n ##[1:20] o_fault_interrupt_output_n);
  cov_active: cover property (@(posedge i_mclk) disable iff (!i_nrst) !o_active ##1 o_active);
  cov_shutdown: cover property (@(posedge i_mclk) disable iff (!i_nrst) o_active ##1 !o_active);
  cov_two_clear: cover property (@(posedge i_mclk) disable iff (!i_nrst)
    flag_two_r != 8'h00 ##1 flag_two_r == 8'h00);
endmodule

//--- tb/bsf_host.sv
// Host model: register strobes and activity request level
module bsf_host (
  input wire logic i_mclk,
  input wire logic [7:0] i_rdata,
  input wire logic i_rvalid,
  output logic o_wr,
  output logic o_rd,
  output logic [7:0] o_addr,
  output logic [7:0] o_wdata,
  output logic o_act
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_addr = 8'h00;
    o_wdata = 8'h00;
    o_act = 1'b0;
  end
  // Released lines show the inverse so a stale value never looks valid
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge i_mclk);
    o_wr = 1'b1;
    o_addr = a;
    o_wdata = v;
    @(negedge i_mclk);
    o_wr = 1'b0;
    o_addr = ~a;
    o_wdata = ~v;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    int n;
    @(negedge i_mclk);
    o_rd = 1'b1;
    o_addr = a;
    @(negedge i_mclk);
    o_rd = 1'b0;
    o_addr = ~a;
    for (n = 0; n < 3 && i_rvalid !== 1'b1; n++) @(negedge i_mclk);
    v = (i_rvalid === 1'b1) ? i_rdata : 8'hXX;
  endtask
  task automatic set_act(input logic v);
    @(negedge i_mclk);
    o_act = v;
  endtask
endmodule

//--- tb/tb.sv
// Testbench: bank choice, activity state and sticky fault flags
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin miscompares++; \
  $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_mclk = 1'b0;
  logic i_nrst = 1'b0;
  logic [15:0] flt = 16'h0000;
  logic wr, rd, rvalid, bank, act, active, irq_n;
  logic [7:0] addr, wdata, rdata, d, m, o;
  logic [7:0] vals [4] = '{8'h01, 8'hFE, 8'hFF, 8'h00};
  int miscompares = 0;
  int compares = 0;
  int cycles = 0;
  always #20 i_mclk = ~i_mclk;
  bsf_host host (.i_mclk(i_mclk), .i_rdata(rdata), .i_rvalid(rvalid), .o_wr(wr), .o_rd(rd),
    .o_addr(addr), .o_wdata(wdata), .o_act(act));
  bsf_bank_fault dut (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_activity_request_input(act),
    .i_fault_one(flt[7:0]), .i_fault_two(flt[15:8]), .i_reg_wr(wr), .i_reg_rd(rd),
    .i_reg_addr(addr), .i_reg_wdata(wdata), .o_reg_rdata(rdata), .o_reg_rvalid(rvalid),
    .o_bank_sel(bank), .o_active(active), .o_fault_interrupt_output_n(irq_n));
  task automatic give_verdict;
    if (miscompares == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge i_mclk);
  endtask
  // Whole run needs under a hundred cycles
  always @(posedge i_mclk) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      give_verdict();
    end
  end
  initial begin
    idle(5);
    i_nrst = 1'b1;
    `CHK({bank, active, irq_n}, 3'b001)
    host.rd(bsf_pkg::BANK_CHOICE_OFS, d);
    `CHK(d, bsf_pkg::BANK_CHOICE_RST)
    host.rd(8'h10, d);
    `CHK(d, 8'h00)
    foreach (vals[i]) begin
      host.wr(bsf_pkg::BANK_CHOICE_OFS, vals[i]);
      idle(2);
      `CHK(bank, vals[i][0])
      host.rd(bsf_pkg::BANK_CHOICE_OFS, d);
      `CHK(d, vals[i])
    end
    for (int a = 1; a >= 0; a--) begin
      host.set_act(a[0]);
      idle(2);
      `CHK(active, a[0])
    end
    for (int r = 0; r < 2; r++) begin
      m = r ? 8'h80 : 8'h08;
      o = r ? bsf_pkg::FAULT_FLAG_TWO_OFS : bsf_pkg::FAULT_FLAG_ONE_OFS;
      @(negedge i_mclk) flt = r ? 16'h8000 : 16'h0008;
      @(negedge i_mclk) flt = 16'h0000;
      idle(3);
      `CHK(irq_n, 1'b0)
      host.wr(o ^ 8'h03, m);
      host.wr(o, ~m);
      idle(3);
      host.rd(o, d);
      `CHK(d, m)
      `CHK(irq_n, 1'b0)
      host.wr(o, m);
      idle(3);
      `CHK(irq_n, 1'b1)
      host.rd(o, d);
      `CHK(d, 8'h00)
    end
    give_verdict();
  end
endmodule
